// [tcc_pkg.sv]
package tcc_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off     = 8'h00;
  localparam logic [7:0] count_lo_off = 8'h04;
  localparam logic [7:0] count_hi_off = 8'h08;
  localparam logic [7:0] gate_off     = 8'h0c;
  localparam logic [7:0] status_off   = 8'h10;
  localparam logic [7:0] mask_off     = 8'h14;
  localparam logic [7:0] sleep_off    = 8'h18;
  // control field positions
  localparam int cs_hi     = 7;
  localparam int cs_lo     = 6;
  localparam int ps_hi     = 5;
  localparam int ps_lo     = 4;
  localparam int osc_bit   = 3;
  localparam int sync_bit  = 2;
  localparam int on_bit    = 0;
  // reset values, count maximum and control write mask
  localparam logic [7:0]  ctrl_rst   = 8'h00;
  localparam logic [15:0] count_rst  = 16'h0000;
  localparam logic [15:0] count_max  = 16'hffff;
  localparam logic [7:0]  ctrl_wmask = 8'hfd;
  // count clock sources
  typedef enum logic [1:0] {
    tcc_src_inst = 2'b00,
    tcc_src_sys  = 2'b01,
    tcc_src_ext  = 2'b10,
    tcc_src_cap  = 2'b11
  } tcc_src_e;
endpackage

// [tcc_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module tcc_edge (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous source and synchroniser bypass
  input  wire logic src,
  input  wire logic bypass,
  // rising edge pulse
  output logic      rise
);
  logic meta;
  logic sync_q;
  logic last;
  logic sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta   <= src;
      sync_q <= meta;
    end
  end

  // the bypass path still needs one sample to find an edge on pclk
  always_comb begin
    sel = bypass ? src : sync_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
    end else begin
      last <= sel;
    end
  end

  assign rise = sel & ~last;
endmodule
`default_nettype wire

// [tcc_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - external source counts pin edges, or crystal when oscillator enabled
// - two source settings (inst and sys) count directly on every system clock
// - prescale 00 none, 01 by 2, 10 by 4, 11 by 8
// - oscillator enable bit drives the dedicated oscillator enable output
// - sync bypass 1 passes the external async input unsynchronised, 0 synchronises it
// - control bit 1 reads zero and ignores writes
// - 16-bit counter wraps ffff to 0000 setting rollover flag
// - in sleep count only asynchronous external mode; wake on enabled rollover
// - gate enable ignored when off; when on, counting follows gate
module tcc_timer (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pins and clock sources
  input  wire logic        ext_count_pin,
  input  wire logic        crystal_osc,
  input  wire logic        cap_sense_oscillator,
  input  wire logic        gate_in,
  input  wire logic        sleep_mode,
  // outputs
  output logic             osc_enable,
  output logic             wake,
  output logic             irq
);
  logic [7:0]  timer_control;
  logic [15:0] count;
  logic        gate_enable;
  logic        rollover_flag;
  logic        rollover_mask;
  logic [2:0]  pre_cnt;
  logic        gate_m;
  logic        gate_s;
  logic        ext_rise;
  logic        cap_rise;
  logic        src_pulse;
  logic        pre_tick;
  logic        run;
  logic        wrap;
  logic        wr;
  logic        rd;
  logic        async_mode;
  logic        ext_src;
  logic [1:0]  cs;
  logic [1:0]  ps;
  logic [2:0]  pre_lim;

  assign cs = timer_control[tcc_pkg::cs_hi:tcc_pkg::cs_lo];
  assign ps = timer_control[tcc_pkg::ps_hi:tcc_pkg::ps_lo];
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  assign ext_src = timer_control[tcc_pkg::osc_bit] ? crystal_osc : ext_count_pin;

  tcc_edge u_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (ext_src),
    .bypass  (timer_control[tcc_pkg::sync_bit]),
    .rise    (ext_rise)
  );

  tcc_edge u_cap (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (cap_sense_oscillator),
    .bypass  (1'b0),
    .rise    (cap_rise)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_m <= 1'b0;
      gate_s <= 1'b0;
    end else begin
      gate_m <= gate_in;
      gate_s <= gate_m;
    end
  end

  // async external mode only in sleep
  assign async_mode = timer_control[tcc_pkg::sync_bit] && cs == tcc_pkg::tcc_src_ext;

  always_comb begin
    case (cs)
      tcc_pkg::tcc_src_inst: src_pulse = 1'b1;
      tcc_pkg::tcc_src_sys:  src_pulse = 1'b1;
      tcc_pkg::tcc_src_ext:  src_pulse = ext_rise;
      default:               src_pulse = cap_rise;
    endcase
  end

  // on bit, gate ignored when off
  assign run = timer_control[tcc_pkg::on_bit] & (~gate_enable | gate_s)
             & (~sleep_mode | async_mode);

  assign pre_lim = 3'((4'h1 << ps) - 4'h1);
  assign pre_tick = run & src_pulse & (pre_cnt >= pre_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 3'h0;
    end else if (wr && paddr == tcc_pkg::ctrl_off) begin
      pre_cnt <= 3'h0;
    end else if (run && src_pulse) begin
      pre_cnt <= pre_tick ? 3'h0 : 3'(pre_cnt + 3'h1);
    end
  end

  assign wrap = pre_tick && count == tcc_pkg::count_max;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= tcc_pkg::count_rst;
    end else if (wr && paddr == tcc_pkg::count_lo_off) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr && paddr == tcc_pkg::count_hi_off) begin
      count[15:8] <= pwdata[7:0];
    end else if (pre_tick) begin
      count <= 16'(count + 16'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control <= tcc_pkg::ctrl_rst;
      gate_enable   <= 1'b0;
      rollover_mask <= 1'b0;
    end else if (wr) begin
      if (paddr == tcc_pkg::ctrl_off) begin
        timer_control <= pwdata[7:0] & tcc_pkg::ctrl_wmask;
      end else if (paddr == tcc_pkg::gate_off) begin
        gate_enable <= pwdata[0];
      end else if (paddr == tcc_pkg::mask_off) begin
        rollover_mask <= pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rollover_flag <= 1'b0;
    end else if (wrap) begin
      rollover_flag <= 1'b1;
    end else if (wr && paddr == tcc_pkg::status_off && pwdata[0]) begin
      rollover_flag <= 1'b0;
    end
  end

  assign osc_enable = timer_control[tcc_pkg::osc_bit];
  assign irq = rollover_flag & rollover_mask;
  assign wake = sleep_mode & irq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == tcc_pkg::ctrl_off) begin
        prdata <= {24'h0, timer_control};
      end else if (paddr == tcc_pkg::count_lo_off) begin
        prdata <= {24'h0, count[7:0]};
      end else if (paddr == tcc_pkg::count_hi_off) begin
        prdata <= {24'h0, count[15:8]};
      end else if (paddr == tcc_pkg::gate_off) begin
        prdata <= {31'h0, gate_enable};
      end else if (paddr == tcc_pkg::status_off) begin
        prdata <= {31'h0, rollover_flag};
      end else if (paddr == tcc_pkg::mask_off) begin
        prdata <= {31'h0, rollover_mask};
      end else if (paddr == tcc_pkg::sleep_off) begin
        prdata <= {30'h0, wake, async_mode};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  a_bit1_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_control[1])
    else $error("control bit 1 set");

  a_bit1_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == tcc_pkg::ctrl_off |=> !prdata[1])
    else $error("control bit 1 read back set");

  a_hold_off: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_control[tcc_pkg::on_bit] && !wr |=> $stable(count))
    else $error("count moved while off");

  a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_control[tcc_pkg::on_bit] |-> !pre_tick)
    else $error("prescaler ticked while off");

  a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wrap |=> rollover_flag && count == tcc_pkg::count_rst)
    else $error("wrap lost");

  a_flag_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rollover_flag) |-> $past(wrap))
    else $error("flag set without wrap");

  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcc_pkg::status_off && pwdata[0] && !wrap |=> !rollover_flag)
    else $error("flag not cleared");

  a_sys_count: assert property (@(posedge pclk) disable iff (!presetn)
    cs == tcc_pkg::tcc_src_sys && ps == 2'b00 && run && !wr
    |=> count == 16'($past(count) + 16'h1))
    else $error("system clock count wrong");

  a_div2_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    pre_tick && ps == 2'b01 && !wr |=> !pre_tick)
    else $error("prescale 2 wrong");

  a_div4_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    pre_tick && ps == 2'b10 && !wr |=> !pre_tick [*3])
    else $error("prescale 4 wrong");

  a_div8_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    pre_tick && ps == 2'b11 |=> !pre_tick [*7])
    else $error("prescale 8 wrong");

  a_pre_restart: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcc_pkg::ctrl_off |=> pre_cnt == 3'h0)
    else $error("prescaler not restarted");

  a_osc_en: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcc_pkg::ctrl_off |=> osc_enable == $past(pwdata[tcc_pkg::osc_bit]))
    else $error("osc enable wrong");

  a_osc_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr |=> $stable(osc_enable))
    else $error("osc enable moved without write");

  // bypass gives edge on raw rise
  a_bypass_edge: assert property (@(posedge pclk) disable iff (!presetn)
    timer_control[tcc_pkg::sync_bit] && $past(timer_control[tcc_pkg::sync_bit])
    && $rose(ext_src) |-> ext_rise)
    else $error("bypass edge lost");

  // raw rise while synchronised
  sequence s_raw_rise;
    $rose(ext_src) && !timer_control[tcc_pkg::sync_bit];
  endsequence

  // synchroniser kept in use
  sequence s_sync_hold;
    !timer_control[tcc_pkg::sync_bit] [*2];
  endsequence

  a_sync_lag: assert property (@(posedge pclk) disable iff (!presetn)
    s_raw_rise ##1 s_sync_hold |-> ext_rise)
    else $error("synchronised edge lost");

  a_sync_cause: assert property (@(posedge pclk) disable iff (!presetn)
    ext_rise && !timer_control[tcc_pkg::sync_bit] && !$past(timer_control[tcc_pkg::sync_bit])
    |-> $past(ext_src, 2) && !$past(ext_src, 3))
    else $error("synchronised edge without cause");

  // no counting in sleep unless async
  a_sleep_stop: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_mode && !async_mode |-> !pre_tick)
    else $error("counted in sleep");

  a_sleep_count: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_mode && async_mode && timer_control[tcc_pkg::on_bit] && !gate_enable
    && ps == 2'b00 && ext_rise |-> pre_tick)
    else $error("async edge lost in sleep");

  a_gate_stop: assert property (@(posedge pclk) disable iff (!presetn)
    gate_enable && !gate_s |-> !pre_tick)
    else $error("counted with gate closed");

  a_gate_free: assert property (@(posedge pclk) disable iff (!presetn)
    timer_control[tcc_pkg::on_bit] && !gate_enable && !sleep_mode
    && cs == tcc_pkg::tcc_src_sys && ps == 2'b00 |-> pre_tick)
    else $error("free count stalled");

  a_src_sel: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_control[tcc_pkg::osc_bit] |-> ext_src == ext_count_pin)
    else $error("source select wrong");

  a_xtal_sel: assert property (@(posedge pclk) disable iff (!presetn)
    timer_control[tcc_pkg::osc_bit] |-> ext_src == crystal_osc)
    else $error("crystal select wrong");
endmodule
`default_nettype wire

// [tcc_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tcc_src_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // run controls
  input  wire logic src_run,
  input  wire logic osc_enable,
  // sources
  output logic      ext_count_pin,
  output logic      crystal_osc,
  output logic      cap_sense_oscillator
);
  logic [1:0] div;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_count_pin        <= 1'h0;
      crystal_osc          <= 1'h0;
      cap_sense_oscillator <= 1'h0;
    end else if (div == 2'h3) begin
      // stopped sources rest low so a restart gives no false edge
      ext_count_pin        <= src_run & ~ext_count_pin;
      cap_sense_oscillator <= src_run & ~cap_sense_oscillator;
      crystal_osc          <= osc_enable & ~crystal_osc;
    end
  end
endmodule
`default_nettype wire

// [test_timer_control_config.sv]
`timescale 1ns/1ps
`default_nettype none
module test_timer_control_config;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        src_run, gate_in, sleep_mode, pin, xtal, cap, osc_enable, wake, irq;
  logic [15:0] cnt, v;
  int          failures, tests_run;
  tcc_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ext_count_pin(pin), .crystal_osc(xtal),
    .cap_sense_oscillator(cap), .gate_in(gate_in), .sleep_mode(sleep_mode),
    .osc_enable(osc_enable), .wake(wake), .irq(irq));
  tcc_src_model i_src (.pclk(pclk), .presetn(presetn), .src_run(src_run),
    .osc_enable(osc_enable), .ext_count_pin(pin), .crystal_osc(xtal),
    .cap_sense_oscillator(cap));
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    // let the access edge settle before callers look at levels
    @(negedge pclk);
    if (k == 20) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic rdcnt();
    xfer(1'h0, tcc_pkg::count_lo_off, 32'h0);
    cnt[7:0] = rd[7:0];
    xfer(1'h0, tcc_pkg::count_hi_off, 32'h0);
    cnt[15:8] = rd[7:0];
  endtask
  task automatic run(input logic [7:0] c, input int n, input logic [15:0] s);
    xfer(1'h1, tcc_pkg::count_lo_off, {24'h0, s[7:0]});
    xfer(1'h1, tcc_pkg::count_hi_off, {24'h0, s[15:8]});
    xfer(1'h1, tcc_pkg::ctrl_off, {24'h0, c});
    repeat (n) @(posedge pclk);
    xfer(1'h1, tcc_pkg::ctrl_off, {24'h0, c & 8'hfe});
    rdcnt();
  endtask
  task automatic near(input int e);
    check({31'h0, cnt >= e - 1 && cnt <= e + 3}, 32'h1);
  endtask
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, src_run, gate_in, sleep_mode} = 6'h04;
    paddr = 8'h0;
    pwdata = 32'h0;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, tcc_pkg::ctrl_off, 32'h0);
    check(rd, 32'h0);
    xfer(1'h1, 8'h1c, 32'hff);
    xfer(1'h0, 8'h1c, 32'h0);
    check(rd, 32'h0);
    check(pslverr, 1'h0);
    xfer(1'h1, tcc_pkg::ctrl_off, 32'hff);
    xfer(1'h0, tcc_pkg::ctrl_off, 32'h0);
    check(rd, 32'hfd);
    xfer(1'h1, tcc_pkg::ctrl_off, 32'h0);
    xfer(1'h0, tcc_pkg::ctrl_off, 32'h0);
    check(rd, 32'h0);
    $display("register test done");
    for (int s = 0; s < 4; s++) begin
      run({s[1:0], 6'h01}, 80, 16'h0);
      near(s < 2 ? 80 : 10);
    end
    for (int p = 0; p < 4; p++) begin
      run({2'h1, p[1:0], 4'h1}, 64, 16'h0);
      near(64 >> p);
    end
    v = cnt;
    repeat (20) @(posedge pclk);
    rdcnt();
    check(cnt, v);
    $display("source test done");
    src_run <= 1'h0;
    run(8'h89, 80, 16'h0);
    near(10);
    check(osc_enable, 1'h1);
    run(8'h81, 80, 16'h0);
    check(cnt, 16'h0);
    check(osc_enable, 1'h0);
    src_run <= 1'h1;
    $display("oscillator test done");
    sleep_mode <= 1'h1;
    run(8'h81, 80, 16'h0);
    check(cnt, 16'h0);
    xfer(1'h1, tcc_pkg::mask_off, 32'h1);
    run(8'h85, 24, 16'hffff);
    near(2);
    check({wake, irq}, 2'h3);
    xfer(1'h0, tcc_pkg::sleep_off, 32'h0);
    check(rd, 32'h3);
    xfer(1'h0, tcc_pkg::status_off, 32'h0);
    check(rd, 32'h1);
    xfer(1'h1, tcc_pkg::mask_off, 32'h0);
    check({wake, irq}, 2'h0);
    xfer(1'h1, tcc_pkg::mask_off, 32'h1);
    xfer(1'h1, tcc_pkg::status_off, 32'h1);
    check(irq, 1'h0);
    sleep_mode <= 1'h0;
    $display("rollover test done");
    xfer(1'h1, tcc_pkg::gate_off, 32'h1);
    xfer(1'h0, tcc_pkg::gate_off, 32'h0);
    check(rd, 32'h1);
    run(8'h41, 40, 16'h0);
    check(cnt, 16'h0);
    gate_in <= 1'h1;
    run(8'h41, 40, 16'h0);
    near(40);
    $display("gate test done");
    complete_run();
  end
  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
